// ### shared/flyback_pkg.sv
package flyback_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned STARTUP_DELAY_NS = 2000;
    localparam int unsigned STARTUP_CYC =
        (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_HZ = 26_000;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int unsigned TIMEOUT_US = 500;
    localparam int unsigned TIMEOUT_TICKS = TIMEOUT_US * TICK_HZ / 1_000_000;
    localparam int unsigned BLANK_MIN_NS = 1500;
    localparam int unsigned BLANK_CYC =
        (BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REFRESH_DUTY_DIV = 20;
    localparam int unsigned REFRESH_CYC = BLANK_CYC * REFRESH_DUTY_DIV;

    // start-up protection counters
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
    localparam logic [CNT_W-1:0] C1_MAX = CNT_W'(TIMEOUT_TICKS);

    // peak current limit code, in tenths of the maximum
    localparam int unsigned ILIM_W = 4;
    localparam logic [ILIM_W-1:0] ILIM_MAX = 4'ha;
    localparam logic [ILIM_W-1:0] ILIM_MIN = 4'h1;

    // register map
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam int unsigned CTRL_ILIM_LSB = 0;
    localparam logic [ILIM_W-1:0] CTRL_ILIM_RST = ILIM_MAX;
    localparam int unsigned ST_FAULT_BIT = 0;
    localparam int unsigned ST_DONE_BIT = 1;
    localparam int unsigned ST_MASTER_BIT = 2;
    localparam int unsigned ST_GATE_BIT = 3;
    localparam int unsigned ST_BOUNDARY_BIT = 4;
    localparam int unsigned ST_BLANK_BIT = 5;
    localparam int unsigned ST_MODE_LSB = 6;
    localparam int unsigned ST_CNT1_LSB = 8;
    localparam int unsigned ST_CNT2_LSB = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_CHARGE,
        MODE_REGULATE,
        MODE_NOLOAD
    } mode_e;

endpackage

// ### design/event_sync.sv
// two-stage synchroniser with rising-edge detect per bit
module event_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] last;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_level <= '0;
            last <= '0;
        end else begin
            meta <= i_async;
            o_level <= meta;
            last <= o_level;
        end
    end

    assign o_rise = o_level & ~last;

endmodule // event_sync

// ### design/flyback_charge_sequencer.sv
// Summary of operation
// - supply window trip latches fault, stops switching
// - fault clears only by charge toggle
// - internal undervoltage also latches fault
// - done low on target reached or fault
// - charge high starts cycle or enables regulation
// - charge low stops at once, shutdown
// - clamp select picks low or high clamp
// - feedback level selects one of three modes
// - feedback below low threshold means charge mode
// - current limit maximum in charge, reducible otherwise
// - first switch-on 2 us after charge rises
// - master latch holds until target or fault
// - current limit turns gate off
// - target during transfer ends cycle, done low
// - demag detect turns gate on again
// - start-up mode paced by tick and aux comparator
// - switch-on by demag or protection, first wins
// - each aux trip adds one tick of wait
// - first demag loads count C1_MAX (13, below the saturation value 15); timeout returns
// - count zero at start-up, fires after one tick
// - second counter cleared when gate rises
// - mode latch lowers demag offset in boundary mode
// - regulation window or no-load above it
// - refresh clock blanks switching, 1/20 duty
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module flyback_charge_sequencer
    import flyback_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // host pins
    input wire logic i_charge,
    input wire logic i_clamp_sel,
    // comparators
    input wire logic i_xfmr_undervolt_sense,
    input wire logic i_xfmr_overvolt_sense,
    input wire logic i_input_undervolt_sense,
    input wire logic i_input_overvolt_sense,
    input wire logic i_internal_uvlo,
    input wire logic i_feedback_sense_low,
    input wire logic i_feedback_sense_high,
    input wire logic i_current_limit,
    input wire logic i_aux_current_limit,
    input wire logic i_demag_detect,
    input wire logic i_output_target,
    // switch and analogue controls
    output logic o_gate,
    output logic o_clamp_low,
    output logic [ILIM_W-1:0] o_ilim_code,
    output logic o_demag_offset_low,
    // open-drain flags
    output logic o_fault_flag_n_o,
    output logic o_fault_flag_n_oe,
    output logic o_done_flag_n_o,
    output logic o_done_flag_n_oe,
    // axi4-lite slave
    input wire logic i_awvalid,
    input wire logic [ADDR_W-1:0] i_awaddr,
    output logic o_awready,
    input wire logic i_wvalid,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_wready,
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_arready,
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready
);

    localparam int NS = 12;
    localparam int TICK_W = $clog2(TICK_DIV);
    localparam int DLY_W = $clog2(STARTUP_CYC + 1);
    localparam int REF_W = $clog2(REFRESH_CYC);

    // 0 unmapped, 1 control, 2 status
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        if (a == ADDR_CTRL) begin
            return 2'h1;
        end else if (a == ADDR_STATUS) begin
            return 2'h2;
        end else begin
            return 2'h0;
        end
    endfunction

    logic [NS-1:0] lvl;
    logic [NS-1:0] rise;
    logic chg_lvl, chg_rise, lock_lvl, uvlo_lvl, trip;
    logic fb_lo, fb_hi, ilim_rise, aux_rise, demag_rise, tgt_lvl;
    logic fault, done, master, boundary, blank, tick;
    logic startup_fire, prot_fire, sw_set, kill;
    mode_e mode;
    logic [TICK_W-1:0] div;
    logic [DLY_W-1:0] dly;
    logic [REF_W-1:0] ref_cnt;
    logic [CNT_W-1:0] cnt1, cnt2;
    logic [ILIM_W-1:0] ctrl_ilim;

    event_sync #(.WIDTH(NS)) sync_u (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_charge, i_xfmr_undervolt_sense, i_xfmr_overvolt_sense,
                  i_input_undervolt_sense, i_input_overvolt_sense,
                  i_internal_uvlo, i_feedback_sense_low,
                  i_feedback_sense_high, i_current_limit,
                  i_aux_current_limit, i_demag_detect, i_output_target}),
        .o_level(lvl),
        .o_rise(rise)
    );

    assign chg_lvl = lvl[11];
    assign chg_rise = rise[11];
    assign lock_lvl = |lvl[10:7];
    assign uvlo_lvl = lvl[6];
    assign fb_lo = lvl[5];
    assign fb_hi = lvl[4];
    assign ilim_rise = rise[3];
    assign aux_rise = rise[2];
    assign demag_rise = rise[1];
    assign tgt_lvl = lvl[0];

    assign trip = lock_lvl || uvlo_lvl;
    assign kill = !chg_lvl || fault || trip;
    assign startup_fire = (dly == DLY_W'(1));
    // protection output: enough ticks since the gate last rose
    assign prot_fire = tick && (cnt2 >= cnt1) && master && !o_gate;
    // first of demag one-shot or protection output wins
    assign sw_set = startup_fire || (master && !o_gate && !blank &&
        !tgt_lvl && (demag_rise || prot_fire));
    assign blank = (mode == MODE_REGULATE) &&
        (ref_cnt < REF_W'(BLANK_CYC));

    // 26 kHz tick, stopped in shutdown
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !chg_lvl) begin
            div <= '0;
            tick <= 1'b0;
        end else if (div == TICK_W'(TICK_DIV - 1)) begin
            div <= '0;
            tick <= 1'b1;
        end else begin
            div <= div + 1'b1;
            tick <= 1'b0;
        end
    end

    // start-up one-shot delay after charge rises
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !chg_lvl) begin
            dly <= '0;
        end else if (chg_rise) begin
            dly <= DLY_W'(STARTUP_CYC);
        end else if (dly != '0) begin
            dly <= dly - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !chg_lvl) begin
            fault <= 1'b0;
        end else if (trip) begin
            fault <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode <= MODE_CHARGE;
        end else if (fb_lo) begin
            mode <= MODE_CHARGE;
        end else if (fb_hi) begin
            mode <= MODE_NOLOAD;
        end else begin
            mode <= MODE_REGULATE;
        end
    end

    // refresh clock, runs only in regulation
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || mode != MODE_REGULATE) begin
            ref_cnt <= '0;
        end else if (ref_cnt == REF_W'(REFRESH_CYC - 1)) begin
            ref_cnt <= '0;
        end else begin
            ref_cnt <= ref_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || kill) begin
            master <= 1'b0;
        end else if (startup_fire) begin
            master <= 1'b1;
        end else if (mode == MODE_CHARGE && tgt_lvl && !o_gate) begin
            master <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !chg_lvl) begin
            done <= 1'b0;
        end else if (mode == MODE_CHARGE && master && !o_gate && tgt_lvl) begin
            done <= 1'b1;
        end
    end

    // switch latch drives the gate directly
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || kill) begin
            o_gate <= 1'b0;
        end else if (o_gate && ilim_rise) begin
            o_gate <= 1'b0;
        end else if (sw_set) begin
            o_gate <= 1'b1;
        end
    end

    // mode latch and first counter (required tick count)
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !chg_lvl) begin
            boundary <= 1'b0;
            cnt1 <= '0;
        end else if (demag_rise && master && !boundary) begin
            boundary <= 1'b1;
            cnt1 <= C1_MAX;
        end else if (prot_fire && boundary) begin
            boundary <= 1'b0;
            cnt1 <= '0;
        end else if (aux_rise && cnt1 != CNT_MAX) begin
            cnt1 <= cnt1 + 1'b1;
        end
    end

    // second counter: ticks since the gate last rose
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !chg_lvl) begin
            cnt2 <= '0;
        end else if (sw_set && !o_gate) begin
            cnt2 <= '0;
        end else if (tick && cnt2 != CNT_MAX) begin
            cnt2 <= cnt2 + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_fault_flag_n_o <= 1'b0;
            o_fault_flag_n_oe <= 1'b0;
            o_done_flag_n_o <= 1'b0;
            o_done_flag_n_oe <= 1'b0;
            o_clamp_low <= 1'b0;
            o_demag_offset_low <= 1'b0;
            o_ilim_code <= ILIM_MAX;
        end else begin
            o_fault_flag_n_oe <= fault;
            o_done_flag_n_oe <= done || fault;
            o_clamp_low <= i_clamp_sel;
            o_demag_offset_low <= boundary;
            if (mode == MODE_CHARGE || ctrl_ilim > ILIM_MAX) begin
                o_ilim_code <= ILIM_MAX;
            end else if (ctrl_ilim < ILIM_MIN) begin
                o_ilim_code <= ILIM_MIN;
            end else begin
                o_ilim_code <= ctrl_ilim;
            end
        end
    end

    // axi4-lite write side
    logic aw_got, w_got, do_write, next_aw_got, next_w_got;
    logic [ADDR_W-1:0] aw_addr;
    assign do_write = aw_got && w_got && !o_bvalid;
    assign next_aw_got = (aw_got && !do_write) || (i_awvalid && o_awready);
    assign next_w_got = (w_got && !do_write) || (i_wvalid && o_wready);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            aw_addr <= '0;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            o_awready <= !next_aw_got;
            o_wready <= !next_w_got;
            if (i_awvalid && o_awready) begin
                aw_addr <= i_awaddr;
            end
        end
    end

    logic w_strb0;
    logic [31:0] w_data;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            w_strb0 <= 1'b0;
            w_data <= '0;
        end else if (i_wvalid && o_wready) begin
            w_strb0 <= i_wstrb[0];
            w_data <= i_wdata;
        end
    end

    // data is applied once both address and data are held
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_ilim <= CTRL_ILIM_RST;
        end else if (do_write && decode(aw_addr) == 2'h1 && w_strb0) begin
            ctrl_ilim <= w_data[CTRL_ILIM_LSB +: ILIM_W];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= (decode(aw_addr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // axi4-lite read side
    logic next_rvalid;
    logic [31:0] status_word;
    assign next_rvalid = (o_rvalid && !i_rready) || (i_arvalid && o_arready);
    always_comb begin
        status_word = '0;
        status_word[ST_FAULT_BIT] = fault;
        status_word[ST_DONE_BIT] = done;
        status_word[ST_MASTER_BIT] = master;
        status_word[ST_GATE_BIT] = o_gate;
        status_word[ST_BOUNDARY_BIT] = boundary;
        status_word[ST_BLANK_BIT] = blank;
        status_word[ST_MODE_LSB +: 2] = mode;
        status_word[ST_CNT1_LSB +: CNT_W] = cnt1;
        status_word[ST_CNT2_LSB +: CNT_W] = cnt2;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end else begin
            o_arready <= !next_rvalid;
            o_rvalid <= next_rvalid;
            if (i_arvalid && o_arready) begin
                case (decode(i_araddr))
                    2'h1: begin
                        o_rdata <= 32'(ctrl_ilim);
                        o_rresp <= RESP_OKAY;
                    end
                    2'h2: begin
                        o_rdata <= status_word;
                        o_rresp <= RESP_OKAY;
                    end
                    default: begin
                        o_rdata <= '0;
                        o_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence clean_s;
        chg_lvl && !trip && !fault;
    endsequence
    sequence start_s;
        !chg_lvl ##1 chg_lvl;
    endsequence

    fault_trip_a: assert property (chg_lvl && lock_lvl |=>
        fault && !o_gate) else $error("lockout did not stop switching");
    uvlo_fault_a: assert property ((i_internal_uvlo && i_charge) [*4]
        |-> fault) else $error("internal undervoltage not latched");
    fault_hold_a: assert property (fault && chg_lvl |=> fault)
        else $error("fault cleared without charge toggle");
    done_fault_a: assert property (fault |=> o_done_flag_n_oe &&
        o_fault_flag_n_oe) else $error("flags not pulled with fault");
    startup_time_a: assert property (startup_fire |->
        $past(chg_lvl, 20) && !$past(chg_lvl, 21))
        else $error("start-up one-shot not 20 cycles after charge");
    startup_quiet_a: assert property (start_s |=> !o_gate [*8])
        else $error("gate rose too soon after charge");
    startup_on_a: assert property (clean_s ##0 startup_fire |=>
        o_gate && master) else $error("start-up did not turn gate on");
    master_hold_a: assert property (clean_s ##0 master &&
        !(tgt_lvl && mode == MODE_CHARGE && !o_gate) |=> master)
        else $error("master latch dropped early");
    cur_limit_a: assert property (o_gate && ilim_rise |=> !o_gate)
        else $error("current limit did not turn gate off");
    target_done_a: assert property (clean_s ##0 master && !o_gate &&
        tgt_lvl && mode == MODE_CHARGE |=> !master && done && !o_gate)
        else $error("target did not end the cycle");
    demag_on_a: assert property (clean_s ##0 master && !o_gate &&
        demag_rise && !blank && !tgt_lvl |=> o_gate)
        else $error("demag did not restart switching");
    first_tick_a: assert property (clean_s ##0 master && !o_gate &&
        cnt1 == '0 && tick && !blank && !tgt_lvl |=> o_gate)
        else $error("zero count did not fire on one tick");
    boundary_a: assert property (chg_lvl && master && demag_rise &&
        !boundary |=> boundary && cnt1 == C1_MAX ##1 o_demag_offset_low)
        else $error("first demag did not enter boundary mode");
    timeout_a: assert property (chg_lvl && boundary && prot_fire |=>
        !boundary && cnt1 == '0) else $error("timeout did not return");
    aux_step_a: assert property (chg_lvl && aux_rise && cnt1 < CNT_MAX &&
        !prot_fire && (boundary || !demag_rise || !master) |=>
        cnt1 == $past(cnt1) + 1'b1) else $error("aux trip did not step");
    cnt2_reset_a: assert property ($rose(o_gate) |-> cnt2 == '0)
        else $error("second counter not cleared on gate rise");
    shutdown_a: assert property (!chg_lvl [*3] |-> !master &&
        !o_gate && !fault && cnt1 == '0 && cnt2 == '0 && !o_done_flag_n_oe)
        else $error("shutdown state not cleared");
    blank_a: assert property (blank && !startup_fire |=> !$rose(o_gate))
        else $error("gate rose during refresh blank");
    mode_a: assert property (!fb_lo && !fb_hi |=>
        mode == MODE_REGULATE) else $error("regulation mode not taken");
    ilim_a: assert property (mode == MODE_CHARGE |=>
        o_ilim_code == ILIM_MAX) else $error("charge limit not maximum");
    clamp_a: assert property (i_clamp_sel |=> o_clamp_low)
        else $error("clamp select not followed");

endmodule // flyback_charge_sequencer

// ### verification/flyback_plant_model.sv
// switch, transformer and output stage seen through their comparators
module flyback_plant_model #(
    parameter int ON_CYC = 5,
    parameter int OFF_CYC = 4
) (
    // switch side
    input wire logic i_clk,
    input wire logic i_gate,
    // scenario controls
    input wire logic i_demag_en,
    input wire logic i_clear,
    input wire logic [7:0] i_target_pulses,
    // comparator outputs
    output logic o_current_limit,
    output logic o_demag_detect,
    output logic o_output_target
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] on_cnt = 8'h00;
    logic [7:0] off_cnt = 8'hff;
    logic [7:0] pulses = 8'h00;
    logic gate_q = 1'b0;
    // primary current ramps only while the switch conducts
    always @(posedge i_clk) begin
        on_cnt <= i_gate ? on_cnt + 8'h01 : 8'h00;
        if (i_gate)
            off_cnt <= 8'h00;
        else if (off_cnt != 8'hff)
            off_cnt <= off_cnt + 8'h01;
        gate_q <= i_gate;
        if (i_clear)
            pulses <= 8'h00;
        else if (i_gate && !gate_q)
            pulses <= pulses + 8'h01;
    end
    assign o_current_limit = i_gate && (on_cnt >= 8'(ON_CYC));
    // ring-down ends a fixed time after turn-off: one short pulse
    assign o_demag_detect = i_demag_en && off_cnt >= 8'(OFF_CYC)
        && off_cnt < 8'(OFF_CYC + 3);
    assign o_output_target = i_target_pulses != 8'h00
        && pulses >= i_target_pulses;
endmodule // flyback_plant_model

// ### verification/testbench.sv
`define CHK(nm, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD %s exp %h got %h", nm, exp, got); \
    end \
end
module testbench
    import flyback_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    int errors = 0, total_checks = 0, rises = 0, on_len = 0, max_on = 0;
    int n, r0;
    logic clk = 1'b0, rst_n = 1'b0, charge = 1'b0, clamp_sel = 1'b0;
    logic fb_low = 1'b1, fb_high = 1'b0, demag_en = 1'b0, gate_q = 1'b0;
    logic [4:0] lock = 5'h00;
    logic [7:0] tgt_n = 8'h00;
    logic cl, dm, tgt, gate, clamp_low, dofs, foe, fo, doe, do_o;
    logic [3:0] ilim;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, aux = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [31:0] vals [3] = '{32'h0, 32'h5, 32'hf};
    logic [3:0] exps [3] = '{4'h1, 4'h5, 4'ha};

    always #50 clk = ~clk;

    flyback_charge_sequencer uut (
        .i_clk(clk), .i_rst_n(rst_n), .i_charge(charge),
        .i_clamp_sel(clamp_sel), .i_xfmr_undervolt_sense(lock[0]),
        .i_xfmr_overvolt_sense(lock[1]), .i_input_undervolt_sense(lock[2]),
        .i_input_overvolt_sense(lock[3]), .i_internal_uvlo(lock[4]),
        .i_feedback_sense_low(fb_low), .i_feedback_sense_high(fb_high),
        .i_current_limit(cl), .i_aux_current_limit(aux),
        .i_demag_detect(dm), .i_output_target(tgt), .o_gate(gate),
        .o_clamp_low(clamp_low), .o_ilim_code(ilim),
        .o_demag_offset_low(dofs), .o_fault_flag_n_o(fo),
        .o_fault_flag_n_oe(foe), .o_done_flag_n_o(do_o),
        .o_done_flag_n_oe(doe), .i_awvalid(awvalid), .i_awaddr(awaddr),
        .o_awready(awready), .i_wvalid(wvalid), .i_wdata(wdata),
        .i_wstrb(4'hf), .o_wready(wready), .o_bvalid(bvalid),
        .o_bresp(bresp), .i_bready(bready), .i_arvalid(arvalid),
        .i_araddr(araddr), .o_arready(arready), .o_rvalid(rvalid),
        .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready));

    flyback_plant_model plant (
        .i_clk(clk), .i_gate(gate), .i_demag_en(demag_en),
        .i_clear(!charge), .i_target_pulses(tgt_n),
        .o_current_limit(cl), .o_demag_detect(dm), .o_output_target(tgt));

    always @(posedge clk) begin
        gate_q <= gate;
        if (gate && !gate_q)
            rises++;
        on_len = gate ? on_len + 1 : 0;
        if (on_len > max_on)
            max_on = on_len;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [3:0] a);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_gate(input int lim);
        n = 0;
        while (!gate && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #2_000_000;
        errors++;
        results();
    end

    initial begin
        tick(3);
        rst_n <= 1'b1;
        tick(2);
        `CHK("idle", 6'h00, {gate, foe, doe, fo, do_o, dofs})
        rdr(ADDR_CTRL);
        `CHK("ctrl_rst", 32'h0000000a, rd)
        wr(4'h8, 32'h0);
        `CHK("wr_unmapped", RESP_SLVERR, resp)
        rdr(4'hc);
        `CHK("rd_unmapped", {RESP_SLVERR, 32'h0}, {resp, rd})
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            clamp_sel <= c[0];
            tick(3);
            `CHK("clamp", c[0], clamp_low)
        end
        $display("test registers finished");
        @(posedge clk);
        charge <= 1'b1;
        wait_gate(40);
        `CHK("first_on", 1'b1, n >= 20 && n <= 27)
        r0 = rises;
        tick(1500);
        `CHK("prot_rearm", 1'b1, rises - r0 >= 3)
        `CHK("offs_start", 1'b0, dofs)
        `CHK("ilim_charge", 4'ha, ilim)
        @(posedge clk);
        demag_en <= 1'b1;
        tgt_n <= 8'h28;
        tick(500);
        `CHK("offs_bound", 1'b1, dofs)
        rdr(ADDR_STATUS);
        `CHK("boundary", 1'b1, rd[ST_BOUNDARY_BIT])
        n = 0;
        while (!doe && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK("done", 3'b100, {doe, foe, gate})
        `CHK("gate_on_len", 1'b1, max_on <= 11)
        r0 = rises;
        tick(800);
        `CHK("held_off", r0, rises)
        @(posedge clk);
        charge <= 1'b0;
        tgt_n <= 8'h00;
        tick(5);
        `CHK("shutdown", 2'b00, {doe, gate})
        $display("test charge finished");
        @(posedge clk);
        fb_low <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, vals[i]);
            tick(4);
            `CHK("ilim_reg", exps[i], ilim)
        end
        rdr(ADDR_STATUS);
        `CHK("mode_reg", MODE_REGULATE, rd[7:6])
        @(posedge clk);
        fb_high <= 1'b1;
        charge <= 1'b1;
        tick(4);
        rdr(ADDR_STATUS);
        `CHK("mode_noload", MODE_NOLOAD, rd[7:6])
        @(posedge clk);
        fb_low <= 1'b1;
        tick(4);
        rdr(ADDR_STATUS);
        `CHK("mode_charge", MODE_CHARGE, rd[7:6])
        @(posedge clk);
        charge <= 1'b0;
        $display("test modes finished");
        for (int k = 0; k < 5; k++) begin
            tick(3);
            charge <= 1'b1;
            wait_gate(40);
            `CHK("resume", 1'b1, n < 40)
            tick(20);
            lock[k] <= 1'b1;
            tick(8);
            `CHK("fault", 3'b110, {foe, doe, gate})
            lock[k] <= 1'b0;
            r0 = rises;
            tick(40);
            `CHK("fault_held", 2'b10, {foe, gate})
            `CHK("no_switch", r0, rises)
            charge <= 1'b0;
            tick(5);
            `CHK("fault_clr", 2'b00, {foe, doe})
        end
        $display("test faults finished");
        @(posedge clk);
        charge <= 1'b1;
        tick(4);
        repeat (2) begin
            aux <= 1'b1;
            tick(3);
            aux <= 1'b0;
            tick(3);
        end
        rdr(ADDR_STATUS);
        `CHK("aux_count", 4'h2, rd[ST_CNT1_LSB +: CNT_W])
        tick(40);
        `CHK("offs_bound2", 1'b1, dofs)
        demag_en <= 1'b0;
        tick(5600);
        `CHK("timeout", 1'b0, dofs)
        $display("test start-up protection finished");
        results();
    end
endmodule // testbench
